// >>> lsbc_cfg.svh
// Offsets, field positions, reset values and timing figures for LED control.
`ifndef LSBC_CFG_SVH
`define LSBC_CFG_SVH

// ---------------------------------------------------------------
// Register map
// ---------------------------------------------------------------
`define LSBC_LED_CONTROL_ONE_ADDR 16'h001b
`define LSBC_LED_CONTROL_ONE_RST  16'h0001
`define LSBC_LED_CONTROL_ONE_WMSK 16'hfcff

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define LSBC_EXT_SET_BIT 10
`define LSBC_HOLD_MSB    7
`define LSBC_HOLD_LSB    4
`define LSBC_SEL_MSB     3
`define LSBC_SEL_LSB     2
`define LSBC_DISABLE_BIT 1
`define LSBC_STRETCH_BIT 0

// ---------------------------------------------------------------
// Timing
// ---------------------------------------------------------------
`define LSBC_CLK_HZ       100000000
`define LSBC_STR0_MS      32
`define LSBC_STR1_MS      64
`define LSBC_STR2_MS      102
`define LSBC_CUSTOM_MS    1
`define LSBC_TICK_MS      1
`define LSBC_BLINK_HALF_MS 500
`define LSBC_CYC_PER_MS   (`LSBC_CLK_HZ / 1000)

`endif

// >>> lsbc_led_ctrl.sv
// LED control register, pulse stretching and first indicator pattern.
`timescale 1ns/10ps
`include "lsbc_cfg.svh"

module lsbc_led_ctrl #(
    parameter int STR0_CYC   = `LSBC_STR0_MS * `LSBC_CYC_PER_MS,
    parameter int STR1_CYC   = `LSBC_STR1_MS * `LSBC_CYC_PER_MS,
    parameter int STR2_CYC   = `LSBC_STR2_MS * `LSBC_CYC_PER_MS,
    parameter int CUSTOM_CYC = `LSBC_CUSTOM_MS * `LSBC_CYC_PER_MS,
    parameter int TICK_CYC   = `LSBC_TICK_MS * `LSBC_CYC_PER_MS,
    parameter int HALF_CYC   = `LSBC_BLINK_HALF_MS * `LSBC_CYC_PER_MS
) (
    // Clock and reset
    input  wire logic              CLK,
    input  wire logic              RST,
    // Management register access
    input  wire logic [15:0]       MGMT_ADDR,
    input  wire logic              MGMT_WR,
    input  wire logic              MGMT_RD,
    input  wire logic [15:0]       MGMT_WDATA,
    output logic      [15:0]       MGMT_RDATA,
    output logic                   MGMT_RVALID,
    // Settings held in neighbouring registers
    input  wire logic [3:0]        FIRST_INDICATOR_FUNCTION_LOW,
    input  wire logic [7:0]        BLINK_PATTERN_BITS,
    input  wire logic [5:0]        PATTERN_TICK_LENGTH,
    input  wire logic [5:0]        STRETCH_CUSTOM_LENGTH,
    // Link state and events
    input  wire logic              LINK_UP,
    input  wire logic              TX_EVENT,
    input  wire logic              RX_EVENT,
    input  wire logic              COL_EVENT,
    // Indicator outputs
    output lsbc_pkg::lsbc_func_t   FIRST_INDICATOR_FUNCTION,
    output logic                   FIRST_INDICATOR_PIN,
    output logic                   TX_INDICATOR,
    output logic                   RX_INDICATOR,
    output logic                   COL_INDICATOR,
    output logic                   INDICATOR_OUTPUT_ENABLE
);
    import lsbc_pkg::*;

    // ---------------------------------------------------------------
    // Control register
    // ---------------------------------------------------------------
    logic [15:0] ctl_ff;
    logic [15:0] nxt_ctl;
    logic [15:0] rdata_ff;
    logic [15:0] nxt_rdata;
    logic        rvalid_ff;
    logic        nxt_rvalid;
    logic        hit;

    assign hit = (MGMT_ADDR == `LSBC_LED_CONTROL_ONE_ADDR);

    always_comb begin
        nxt_ctl = ctl_ff;
        if (MGMT_WR && hit) begin
            nxt_ctl = (MGMT_WDATA & `LSBC_LED_CONTROL_ONE_WMSK) |
                      (ctl_ff & ~`LSBC_LED_CONTROL_ONE_WMSK);
        end
        nxt_rdata  = rdata_ff;
        nxt_rvalid = MGMT_RD;
        if (MGMT_RD) begin
            nxt_rdata = hit ? ctl_ff : 16'h0000;
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            ctl_ff    <= `LSBC_LED_CONTROL_ONE_RST;
            rdata_ff  <= 16'h0000;
            rvalid_ff <= 1'b0;
        end else begin
            ctl_ff    <= nxt_ctl;
            rdata_ff  <= nxt_rdata;
            rvalid_ff <= nxt_rvalid;
        end
    end

    logic       ext_set_enable;
    logic [3:0] pattern_hold_length;
    lsbc_sel_t  stretch_length_select;
    logic       indicator_output_disable;
    logic       stretch_enable;

    assign ext_set_enable        = ctl_ff[`LSBC_EXT_SET_BIT];
    assign pattern_hold_length   = ctl_ff[`LSBC_HOLD_MSB:`LSBC_HOLD_LSB];
    assign stretch_length_select =
        lsbc_sel_t'(ctl_ff[`LSBC_SEL_MSB:`LSBC_SEL_LSB]);
    assign indicator_output_disable = ctl_ff[`LSBC_DISABLE_BIT];
    assign stretch_enable        = ctl_ff[`LSBC_STRETCH_BIT];

    // ---------------------------------------------------------------
    // Pulse stretching
    // ---------------------------------------------------------------
    logic [31:0] stretch_cycles;
    logic [2:0]  stretched;

    always_comb begin
        unique case (stretch_length_select)
            SEL_32MS:   stretch_cycles = 32'(STR0_CYC);
            SEL_64MS:   stretch_cycles = 32'(STR1_CYC);
            SEL_102MS:  stretch_cycles = 32'(STR2_CYC);
            SEL_CUSTOM: stretch_cycles =
                32'(STRETCH_CUSTOM_LENGTH) * 32'(CUSTOM_CYC);
        endcase
    end

    lsbc_stretch #(
        .N  (3),
        .CW (32)
    ) u_stretch (
        .clk        (CLK),
        .rst        (RST),
        .enable     (stretch_enable),
        .len_cycles (stretch_cycles),
        .ev         ({COL_EVENT, RX_EVENT, TX_EVENT}),
        .stretched  (stretched)
    );

    // ---------------------------------------------------------------
    // Blink source
    // ---------------------------------------------------------------
    lsbc_pat_state_t pat_ff;
    lsbc_pat_state_t nxt_pat;
    logic [31:0]     tick_ff;
    logic [31:0]     nxt_tick;
    logic [2:0]      idx_ff;
    logic [2:0]      nxt_idx;
    logic [3:0]      hold_ff;
    logic [3:0]      nxt_hold;
    logic            blink_ff;
    logic            nxt_blink;
    logic [31:0]     tick_cycles;
    logic            tick_end;

    assign tick_cycles = (PATTERN_TICK_LENGTH == 6'h00) ? 32'(HALF_CYC) :
                         32'(PATTERN_TICK_LENGTH) * 32'(TICK_CYC);
    assign tick_end    = (tick_ff >= tick_cycles - 32'h1);

    always_comb begin
        nxt_pat   = pat_ff;
        nxt_idx   = idx_ff;
        nxt_hold  = hold_ff;
        nxt_blink = blink_ff;
        nxt_tick  = tick_end ? 32'h0 : tick_ff + 32'h1;
        if (tick_end) begin
            if (PATTERN_TICK_LENGTH == 6'h00) begin
                nxt_blink = ~blink_ff;
                nxt_pat   = PAT_SHIFT;
                nxt_idx   = 3'h0;
            end else begin
                unique case (pat_ff)
                    PAT_SHIFT: begin
                        nxt_blink = BLINK_PATTERN_BITS[idx_ff];
                        nxt_idx   = idx_ff + 3'h1;
                        if (idx_ff == 3'h7 && pattern_hold_length != 4'h0)
                        begin
                            nxt_pat  = PAT_HOLD;
                            nxt_hold = pattern_hold_length;
                        end
                    end
                    PAT_HOLD: begin
                        nxt_hold = hold_ff - 4'h1;
                        if (hold_ff == 4'h1) begin
                            nxt_pat = PAT_SHIFT;
                        end
                    end
                endcase
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            pat_ff   <= PAT_SHIFT;
            tick_ff  <= 32'h0;
            idx_ff   <= 3'h0;
            hold_ff  <= 4'h0;
            blink_ff <= 1'b0;
        end else begin
            pat_ff   <= nxt_pat;
            tick_ff  <= nxt_tick;
            idx_ff   <= nxt_idx;
            hold_ff  <= nxt_hold;
            blink_ff <= nxt_blink;
        end
    end

    // ---------------------------------------------------------------
    // Indicator outputs
    // ---------------------------------------------------------------
    lsbc_func_t func;
    logic       act;
    logic       first_val;
    logic [4:0] out_ff;
    logic [4:0] nxt_out;
    lsbc_func_t func_ff;

    assign func = {ext_set_enable, FIRST_INDICATOR_FUNCTION_LOW};
    assign act  = stretched[0] | stretched[1];

    always_comb begin
        unique case (func)
            5'h04:   first_val = LINK_UP;
            5'h05:   first_val = stretched[0];
            5'h06:   first_val = stretched[1];
            5'h07:   first_val = act;
            5'h09:   first_val = stretched[2];
            5'h0a:   first_val = LINK_UP & ~(act & blink_ff);
            5'h0b:   first_val = LINK_UP & ~(stretched[1] & blink_ff);
            5'h0d:   first_val = blink_ff;
            5'h0e:   first_val = 1'b1;
            5'h19:   first_val = act & blink_ff;
            5'h1a:   first_val = stretched[0] & blink_ff;
            default: first_val = 1'b0;
        endcase
        nxt_out = indicator_output_disable ? 5'h00 :
                  {1'b1, stretched, first_val};
    end

    always_ff @(posedge CLK) begin
        if (RST) begin
            out_ff  <= 5'h00;
            func_ff <= 5'h00;
        end else begin
            out_ff  <= nxt_out;
            func_ff <= func;
        end
    end

    assign MGMT_RDATA               = rdata_ff;
    assign MGMT_RVALID              = rvalid_ff;
    assign FIRST_INDICATOR_FUNCTION = func_ff;
    assign FIRST_INDICATOR_PIN      = out_ff[0];
    assign TX_INDICATOR             = out_ff[1];
    assign RX_INDICATOR             = out_ff[2];
    assign COL_INDICATOR            = out_ff[3];
    assign INDICATOR_OUTPUT_ENABLE  = out_ff[4];

    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    a_disable_dark: assert property (@(posedge CLK) disable iff (RST)
        indicator_output_disable |=> !INDICATOR_OUTPUT_ENABLE &&
        !FIRST_INDICATOR_PIN && !TX_INDICATOR)
        else $error("indicators driven while disabled");
    a_enable_drive: assert property (@(posedge CLK) disable iff (RST)
        !indicator_output_disable |=> INDICATOR_OUTPUT_ENABLE)
        else $error("indicators not enabled");
    a_ext_bit_msb: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> FIRST_INDICATOR_FUNCTION[4] == $past(ctl_ff[10]))
        else $error("function code top bit wrong");
    a_func_low: assert property (@(posedge CLK) disable iff (RST)
        1'b1 |=> FIRST_INDICATOR_FUNCTION[3:0] ==
        $past(FIRST_INDICATOR_FUNCTION_LOW))
        else $error("function code low bits wrong");
    a_sel_32ms: assert property (@(posedge CLK) disable iff (RST)
        ctl_ff[3:2] == 2'h0 |-> stretch_cycles == 32'(STR0_CYC))
        else $error("stretch select 0 length wrong");
    a_sel_custom: assert property (@(posedge CLK) disable iff (RST)
        ctl_ff[3:2] == 2'h3 |-> stretch_cycles ==
        32'(STRETCH_CUSTOM_LENGTH) * 32'(CUSTOM_CYC))
        else $error("custom stretch length wrong");
    a_hold_load: assert property (@(posedge CLK) disable iff (RST)
        pat_ff == PAT_SHIFT && nxt_pat == PAT_HOLD |=>
        hold_ff == $past(pattern_hold_length))
        else $error("hold count not loaded");
    a_hold_steady: assert property (@(posedge CLK) disable iff (RST)
        pat_ff == PAT_HOLD && PATTERN_TICK_LENGTH != 6'h00 |=>
        blink_ff == $past(blink_ff))
        else $error("pattern bit changed during hold");
    a_default_blink: assert property (@(posedge CLK) disable iff (RST)
        PATTERN_TICK_LENGTH == 6'h00 && tick_end |=>
        blink_ff != $past(blink_ff))
        else $error("default blink did not toggle");
    a_reserved_zero: assert property (@(posedge CLK) disable iff (RST)
        ctl_ff[9:8] == 2'h0)
        else $error("read-only bits changed");
    a_write_stores: assert property (@(posedge CLK) disable iff (RST)
        MGMT_WR && hit |=> ctl_ff[0] == $past(MGMT_WDATA[0]))
        else $error("stretch enable not written");

    c_write: cover property (@(posedge CLK) disable iff (RST) MGMT_WR && hit);
    c_hold: cover property (@(posedge CLK) disable iff (RST)
        pat_ff == PAT_HOLD);
    c_disable: cover property (@(posedge CLK) disable iff (RST)
        indicator_output_disable ##1 !indicator_output_disable);
endmodule

// >>> lsbc_led_ctrl_tb.sv
// Self-checking bench for the LED control block.
`timescale 1ns/10ps
`include "lsbc_cfg.svh"
module lsbc_led_ctrl_tb;
    import lsbc_pkg::*;
    localparam int S0 = 20;
    localparam int S1 = 40;
    localparam int S2 = 60;
    localparam int CU = 4;
    localparam int TK = 3;
    localparam int HF = 10;
    localparam logic [15:0] ADDR = `LSBC_LED_CONTROL_ONE_ADDR;
    logic        clk, rst, wr, rd, rvalid, pin, txi, rxi, coli, oe;
    logic [15:0] addr, wdata, rdata;
    logic [3:0]  flow, lit;
    logic [7:0]  pat;
    logic [5:0]  tick, clen;
    logic [2:0]  ev;
    lsbc_func_t  func;
    logic [15:0] exp_q[$];
    int          bad_count, checks_done, dur, want, k, h;

    lsbc_led_ctrl #(.STR0_CYC(S0), .STR1_CYC(S1), .STR2_CYC(S2),
        .CUSTOM_CYC(CU), .TICK_CYC(TK), .HALF_CYC(HF)) dut (
        .CLK(clk), .RST(rst), .MGMT_ADDR(addr), .MGMT_WR(wr),
        .MGMT_RD(rd), .MGMT_WDATA(wdata), .MGMT_RDATA(rdata),
        .MGMT_RVALID(rvalid), .FIRST_INDICATOR_FUNCTION_LOW(flow),
        .BLINK_PATTERN_BITS(pat), .PATTERN_TICK_LENGTH(tick),
        .STRETCH_CUSTOM_LENGTH(clen), .LINK_UP(1'b1), .TX_EVENT(ev[0]),
        .RX_EVENT(ev[1]), .COL_EVENT(ev[2]),
        .FIRST_INDICATOR_FUNCTION(func), .FIRST_INDICATOR_PIN(pin),
        .TX_INDICATOR(txi), .RX_INDICATOR(rxi), .COL_INDICATOR(coli),
        .INDICATOR_OUTPUT_ENABLE(oe));

    lsbc_led_model leds (.pins({pin, coli, rxi, txi}), .oe(oe), .lit(lit));

    always #5 clk = ~clk;

    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic finish_test();
        $display("Checks %0d, mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
        @(negedge clk);
        addr = a;
        wdata = d;
        wr = 1'b1;
        @(negedge clk);
        wr = 1'b0;
        repeat (3) @(negedge clk);
    endtask

    task automatic rd_reg(input logic [15:0] a, input logic [15:0] e);
        @(negedge clk);
        exp_q.push_back(e);
        addr = a;
        rd = 1'b1;
        @(negedge clk);
        rd = 1'b0;
        repeat (2) @(negedge clk);
    endtask

    task automatic pulse(input int i);
        @(negedge clk);
        ev[i] = 1'b1;
        @(negedge clk);
        ev = 3'h0;
    endtask

    task automatic count_high(input int i, output int n);
        n = 0;
        while (lit[i] === 1'b1 && n < 2000) begin
            @(negedge clk);
            n++;
        end
    endtask

    task automatic run_len(input int i, output int n);
        int w;
        w = 0;
        while (lit[i] !== 1'b0 && w < 2000) begin
            @(negedge clk);
            w++;
        end
        while (lit[i] !== 1'b1 && w < 4000) begin
            @(negedge clk);
            w++;
        end
        count_high(i, n);
    endtask

    // Read data is compared with the oldest expectation when it appears.
    always @(posedge clk) begin
        if (rvalid === 1'b1) begin
            // Read data with no read outstanding is a mismatch.
            if (exp_q.size() > 0)
                check(rdata, exp_q.pop_front());
            else
                check(16'h0001, 16'h0000);
        end
    end

    initial begin
        #500000;
        bad_count++;
        finish_test();
    end

    initial begin
        clk = 1'b0; rst = 1'b1; wr = 1'b0; rd = 1'b0; addr = 16'h0000;
        wdata = 16'h0000; ev = 3'h0; pat = 8'h00; tick = 6'h00;
        bad_count = 0; checks_done = 0;
        k = $urandom(32'h95c99d84);
        flow = 4'($urandom_range(0, 15));
        clen = 6'h01;
        repeat (3) @(negedge clk);
        rst = 1'b0;
        rd_reg(ADDR, `LSBC_LED_CONTROL_ONE_RST);
        rd_reg(16'h001c, 16'h0000);
        wr_reg(16'h001c, 16'hffff);
        rd_reg(ADDR, 16'h0001);
        wr_reg(ADDR, 16'hffff);
        rd_reg(ADDR, 16'hfcff);
        check({11'h0, func}, {11'h0, 1'b1, flow});
        wr_reg(ADDR, 16'h0001);
        check({11'h0, func}, {11'h0, 1'b0, flow});
        $display("Test register access done");
        wr_reg(ADDR, 16'h0003);
        pulse(0);
        repeat (3) @(negedge clk);
        check({14'h0, oe, txi}, 16'h0000);
        wr_reg(ADDR, 16'h0001);
        check({15'h0, oe}, 16'h0001);
        // Let the transmit stretch from the dark pulse run out first.
        repeat (S0 + 4) @(negedge clk);
        $display("Test output disable done");
        // stretch lengths for every select code
        for (k = 0; k < 4; k++) begin
            clen = 6'($urandom_range(1, 8));
            wr_reg(ADDR, 16'(k << 2) | 16'h0001);
            pulse(k % 3);
            run_len(k % 3, dur);
            want = k == 0 ? S0 : k == 1 ? S1 : k == 2 ? S2 : int'(clen) * CU;
            check(16'(dur >= want && dur <= want + 2), 16'h0001);
        end
        $display("Test stretch lengths done");
        wr_reg(ADDR, 16'h0000);
        for (k = 0; k < 3; k++) begin
            pulse(k);
            run_len(k, dur);
            check(16'(dur), 16'h0001);
        end
        // a second event restarts the interval
        wr_reg(ADDR, 16'h0001);
        pulse(1);
        repeat (8) @(negedge clk);
        pulse(1);
        count_high(1, dur);
        check(16'(dur >= S0 - 2 && dur <= S0 + 2), 16'h0001);
        $display("Test stretch enable and restart done");
        flow = 4'hd;
        tick = 6'h00;
        wr_reg(ADDR, 16'h0001);
        run_len(3, dur);
        check(16'(dur), 16'(HF));
        tick = 6'h01;
        pat = 8'h80;
        for (h = 0; h < 3; h++) begin
            // The first pass runs without hold, the others with one.
            k = (h == 0) ? 0 : int'($urandom_range(1, 3));
            wr_reg(ADDR, 16'(k << 4) | 16'h0001);
            run_len(3, dur);
            check(16'(dur), 16'(TK * (1 + k)));
        end
        $display("Test blink and hold done");
        repeat (4) @(negedge clk);
        // Every read issued must have been answered.
        check(16'(exp_q.size()), 16'h0000);
        finish_test();
    end
endmodule

// >>> lsbc_led_model.sv
// Behavioural model of the indicator LEDs on the pin side.
`timescale 1ns/10ps
module lsbc_led_model (
    // Pins
    input  wire logic [3:0] pins,
    input  wire logic       oe,
    // Observed light
    output logic      [3:0] lit
);
    // An LED lights only while its pin is high and the outputs are enabled.
    always_comb begin
        lit = oe ? pins : 4'h0;
    end
endmodule

// >>> lsbc_pkg.sv
// Types shared by the LED control block.
package lsbc_pkg;
    typedef enum logic [1:0] {
        SEL_32MS,
        SEL_64MS,
        SEL_102MS,
        SEL_CUSTOM
    } lsbc_sel_t;

    typedef enum logic {
        PAT_SHIFT,
        PAT_HOLD
    } lsbc_pat_state_t;

    typedef logic [4:0] lsbc_func_t;
endpackage

// >>> lsbc_stretch.sv
// Pulse stretcher for a group of indicator events.
`timescale 1ns/10ps
module lsbc_stretch #(
    parameter int N  = 3,
    parameter int CW = 32
) (
    // Clock and reset
    input  wire logic          clk,
    input  wire logic          rst,
    // Control
    input  wire logic          enable,
    input  wire logic [CW-1:0] len_cycles,
    // Events
    input  wire logic [N-1:0]  ev,
    output logic      [N-1:0]  stretched
);
    logic [CW-1:0] cnt_ff [N];
    logic [CW-1:0] nxt_cnt [N];
    logic [N-1:0]  out_ff;
    logic [N-1:0]  nxt_out;

    always_comb begin
        for (int i = 0; i < N; i++) begin
            nxt_cnt[i] = '0;
            nxt_out[i] = 1'b0;
            if (!enable) begin
                nxt_out[i] = ev[i];
            end else if (ev[i]) begin
                nxt_cnt[i] = len_cycles;
                nxt_out[i] = 1'b1;
            end else if (cnt_ff[i] > CW'(1)) begin
                nxt_cnt[i] = cnt_ff[i] - CW'(1);
                nxt_out[i] = 1'b1;
            end
        end
    end

    always_ff @(posedge clk) begin
        for (int i = 0; i < N; i++) begin
            cnt_ff[i] <= rst ? '0 : nxt_cnt[i];
        end
        out_ff <= rst ? '0 : nxt_out;
    end

    assign stretched = out_ff;

    a_event_lights: assert property (@(posedge clk) disable iff (rst)
        ev[0] |=> stretched[0])
        else $error("event did not light the indicator");
    a_restart_len: assert property (@(posedge clk) disable iff (rst)
        enable && ev[0] |=> cnt_ff[0] == $past(len_cycles))
        else $error("stretch interval not restarted");
    a_release_idle: assert property (@(posedge clk) disable iff (rst)
        enable && !ev[0] && cnt_ff[0] <= CW'(1) |=> !stretched[0])
        else $error("indicator held past its interval");
    a_bypass_pass: assert property (@(posedge clk) disable iff (rst)
        !enable |=> stretched == $past(ev))
        else $error("unstretched path does not follow events");
    c_restart: cover property (@(posedge clk) disable iff (rst)
        enable && ev[0] ##1 !ev[0] ##1 ev[0]);
endmodule
